// ===== src/flash_access_guard.sv
// Flash access guard top: control registers, verdict register, sense control
`timescale 1ns/10ps
`default_nettype none
module flash_access_guard (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [7:0]  sfr_addr,
   input  wire logic        sfr_wr,
   input  wire logic        sfr_rd,
   input  wire logic [7:0]  sfr_wdata,
   output logic      [7:0]  sfr_rdata,
   input  wire logic        req_valid,
   input  wire logic        req_src,
   input  wire logic [1:0]  req_op,
   input  wire logic [15:0] req_addr,
   input  wire logic [15:0] req_pc,
   input  wire logic [7:0]  wrlock_byte,
   input  wire logic [7:0]  rdlock_byte,
   output logic             resp_valid,
   output logic             resp_allow,
   output logic             resp_full_erase,
   output logic             resp_clear_security,
   output logic             resp_zero_read,
   output logic             resp_scratch,
   output logic             sense_amp_on
);
   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic                                  oneshot;
      logic                                  read_always;
      logic                                  prog_gate;
      logic                                  scratch;
      logic                                  erase_en;
      logic                                  write_en;
      logic [7:0]                            limit;
      logic                                  limit_done;
      logic [7:0]                            rdata;
      logic                                  valid;
      logic                                  allow;
      logic                                  full;
      logic                                  clr;
      logic                                  zero;
      logic                                  to_scr;
      logic                                  amp;
      logic [flash_guard_pkg::SENSE_W-1:0]   amp_cnt;
   } state_s;

   localparam logic [flash_guard_pkg::SENSE_W-1:0] HOLD =
      flash_guard_pkg::SENSE_W'(flash_guard_pkg::SENSE_HOLD_CYCLES);

   state_s st_reg;
   state_s st_next;
   logic   is_read;

   guard_if gi ();

   // ************************************************************
   // Judge hookup
   // ************************************************************
   assign gi.src       = flash_guard_pkg::src_e'(req_src);
   assign gi.op        = flash_guard_pkg::op_e'(req_op);
   assign gi.addr      = req_addr;
   assign gi.pc        = req_pc;
   assign gi.limit     = {st_reg.limit, flash_guard_pkg::LIMIT_LOW_BYTE}; // [RULE_21]
   assign gi.scratch   = st_reg.scratch;
   assign gi.prog_gate = st_reg.prog_gate;
   assign gi.write_en  = st_reg.write_en;
   assign gi.erase_en  = st_reg.erase_en;
   assign gi.wrlock    = wrlock_byte;
   assign gi.rdlock    = rdlock_byte;

   access_judge u_judge (
      .g (gi.judge)
   );

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      st_next = st_reg;
      is_read = req_valid && gi.allow &&
                (req_op == flash_guard_pkg::OP_READ || req_op == flash_guard_pkg::OP_FETCH);

      // Register writes
      if (sfr_wr) begin
         if (sfr_addr == flash_guard_pkg::FTC_ADDR) begin
            st_next.oneshot     = sfr_wdata[flash_guard_pkg::FTC_ONESHOT_BIT]; // [RULE_15]
            st_next.read_always = sfr_wdata[flash_guard_pkg::FTC_ALWAYS_BIT];  // [RULE_16]
            st_next.prog_gate   = sfr_wdata[flash_guard_pkg::FTC_GATE_BIT];    // [RULE_18]
         end else if (sfr_addr == flash_guard_pkg::PSC_ADDR) begin
            st_next.scratch  = sfr_wdata[flash_guard_pkg::PSC_SCRATCH_BIT]; // [RULE_20]
            st_next.erase_en = sfr_wdata[flash_guard_pkg::PSC_ERASE_BIT];   // [RULE_19]
            st_next.write_en = sfr_wdata[flash_guard_pkg::PSC_WRITE_BIT];   // [RULE_19]
         end else if (sfr_addr == flash_guard_pkg::ALR_ADDR) begin
            // Write-once per reset so upper code cannot move the limit
            if (!st_reg.limit_done) begin
               st_next.limit      = sfr_wdata;
               st_next.limit_done = 1'b1;
            end
         end
      end

      // Register reads, captured into a flop
      if (sfr_rd) begin
         if (sfr_addr == flash_guard_pkg::FTC_ADDR) begin
            st_next.rdata = {st_reg.oneshot, st_reg.read_always,
                             flash_guard_pkg::FTC_RSVD_VALUE, st_reg.prog_gate}; // [RULE_17]
         end else if (sfr_addr == flash_guard_pkg::PSC_ADDR) begin
            st_next.rdata = {flash_guard_pkg::PSC_UNUSED_VALUE, st_reg.scratch,
                             st_reg.erase_en, st_reg.write_en};
         end else if (sfr_addr == flash_guard_pkg::ALR_ADDR) begin
            st_next.rdata = st_reg.limit;
         end else begin
            st_next.rdata = 8'h00;
         end
      end

      // Verdict, one cycle after the request
      st_next.valid  = req_valid;
      st_next.allow  = req_valid && gi.allow;
      st_next.full   = req_valid && gi.full_erase;
      st_next.clr    = req_valid && gi.clear_sec;
      st_next.zero   = req_valid && gi.zero_read;
      st_next.to_scr = req_valid && st_reg.scratch &&
                       req_src == flash_guard_pkg::SRC_FIRMWARE &&
                       req_op != flash_guard_pkg::OP_FETCH;

      // Sense amplifier control
      if (st_reg.read_always) begin
         st_next.amp     = 1'b1; // [RULE_16]
         st_next.amp_cnt = HOLD;
      end else if (is_read) begin
         st_next.amp     = 1'b1;
         st_next.amp_cnt = HOLD;
      end else if (st_reg.oneshot) begin
         // One-shot saves power; disabled it leaves amps on after a read
         if (st_reg.amp_cnt != '0) begin
            st_next.amp_cnt = st_reg.amp_cnt - 1'b1; // [RULE_15]
         end
         st_next.amp = st_reg.amp_cnt > 1; // [RULE_15]
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_reg             <= '0;
         st_reg.oneshot     <= flash_guard_pkg::FTC_RESET[flash_guard_pkg::FTC_ONESHOT_BIT];
         st_reg.read_always <= flash_guard_pkg::FTC_RESET[flash_guard_pkg::FTC_ALWAYS_BIT];
         st_reg.prog_gate   <= flash_guard_pkg::FTC_RESET[flash_guard_pkg::FTC_GATE_BIT];
         st_reg.scratch     <= flash_guard_pkg::PSC_RESET[flash_guard_pkg::PSC_SCRATCH_BIT];
         st_reg.erase_en    <= flash_guard_pkg::PSC_RESET[flash_guard_pkg::PSC_ERASE_BIT];
         st_reg.write_en    <= flash_guard_pkg::PSC_RESET[flash_guard_pkg::PSC_WRITE_BIT];
         st_reg.limit       <= flash_guard_pkg::ALR_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign sfr_rdata           = st_reg.rdata;
   assign resp_valid          = st_reg.valid;
   assign resp_allow          = st_reg.allow;
   assign resp_full_erase     = st_reg.full;
   assign resp_clear_security = st_reg.clr;
   assign resp_zero_read      = st_reg.zero;
   assign resp_scratch        = st_reg.to_scr;
   assign sense_amp_on        = st_reg.amp;
endmodule : flash_access_guard
`default_nettype wire

// ===== src/flash_guard_pkg.sv
// Constants, encodings and register map of the flash access guard
// Operation
// (RULE_01) Debug port may access unlocked pages
// (RULE_02) Debug port refused on locked pages
// (RULE_03) Debug port may always read security bytes
// (RULE_04) Debug port may always write security bytes
// (RULE_05) Unlocked security page erase clears all locks
// (RULE_06) Locked security page: only full erase
// (RULE_07) Reserved area always refused
// (RULE_08) Lock bytes never restrict firmware
// (RULE_09) Lower firmware may access all but security page
// (RULE_10) Firmware may never erase security page
// (RULE_11) Firmware may read and write security page
// (RULE_12) Upper firmware may access pages above limit
// (RULE_13) Upper firmware refused below the limit
// (RULE_14) Branches below the limit are permitted
// (RULE_15) Timing bit 7 enables sense one-shot
// (RULE_16) Timing bit 6 forces read every cycle
// (RULE_17) Timing bits 5-1 read zero
// (RULE_18) Timing bit 0 gates software write/erase
// (RULE_19) Store write/erase enables default zero, required
// (RULE_20) Scratchpad select redirects to 128-byte sector
// (RULE_21) Limit address is register byte then zero
// (RULE_22) Upper read of lower partition returns zero
// (RULE_23) Firmware classified by issuing program counter
package flash_guard_pkg;
   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [7:0] FTC_ADDR  = 8'hb7;
   localparam logic [7:0] PSC_ADDR  = 8'h8f;
   localparam logic [7:0] ALR_ADDR  = 8'hb5;
   localparam logic [7:0] FTC_RESET = 8'h80;
   localparam logic [7:0] PSC_RESET = 8'h00;
   localparam logic [7:0] ALR_RESET = 8'h00;
   localparam int FTC_ONESHOT_BIT = 7;
   localparam int FTC_ALWAYS_BIT  = 6;
   localparam int FTC_GATE_BIT    = 0;
   localparam int PSC_SCRATCH_BIT = 2;
   localparam int PSC_ERASE_BIT   = 1;
   localparam int PSC_WRITE_BIT   = 0;
   localparam logic [4:0] FTC_RSVD_VALUE = 5'h00;
   localparam logic [4:0] PSC_UNUSED_VALUE = 5'h00;
   localparam logic [7:0] LIMIT_LOW_BYTE = 8'h00;

   // ************************************************************
   // Flash geometry
   // ************************************************************
   localparam logic [15:0] RESERVED_BASE = 16'hfc00;
   localparam logic [15:0] SEC_PAGE_BASE = 16'hfa00;
   localparam logic [15:0] SEC_PAGE_LAST = 16'hfbff;
   localparam logic [15:0] WRLOCK_ADDR   = 16'hfbfe;
   localparam logic [15:0] RDLOCK_ADDR   = 16'hfbff;
   localparam logic [15:0] SCRATCH_SIZE  = 16'h0080;
   localparam int SEC_LOCK_BIT  = 7;
   localparam int BLOCK_MSB     = 15;
   localparam int BLOCK_LSB     = 13;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_PERIOD_PS     = 4000;
   localparam int SENSE_HOLD_NS     = 20;
   localparam int SENSE_HOLD_CYCLES =
      (SENSE_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SENSE_W = 4;

   // ************************************************************
   // Encodings
   // ************************************************************
   typedef enum logic {
      SRC_DEBUG    = 1'b0,
      SRC_FIRMWARE = 1'b1
   } src_e;

   typedef enum logic [1:0] {
      OP_READ  = 2'b00,
      OP_WRITE = 2'b01,
      OP_ERASE = 2'b10,
      OP_FETCH = 2'b11
   } op_e;
endpackage : flash_guard_pkg

// ===== src/guard_if.sv
// Request and verdict bundle between the guard top and its judge
`timescale 1ns/10ps
`default_nettype none
interface guard_if;
   flash_guard_pkg::src_e src;
   flash_guard_pkg::op_e  op;
   logic [15:0]           addr;
   logic [15:0]           pc;
   logic [15:0]           limit;
   logic                  scratch;
   logic                  prog_gate;
   logic                  write_en;
   logic                  erase_en;
   logic [7:0]            wrlock;
   logic [7:0]            rdlock;
   logic                  allow;
   logic                  full_erase;
   logic                  clear_sec;
   logic                  zero_read;

   modport top (
      output src, op, addr, pc, limit, scratch, prog_gate, write_en, erase_en,
      output wrlock, rdlock,
      input  allow, full_erase, clear_sec, zero_read
   );
   modport judge (
      input  src, op, addr, pc, limit, scratch, prog_gate, write_en, erase_en,
      input  wrlock, rdlock,
      output allow, full_erase, clear_sec, zero_read
   );
endinterface : guard_if
`default_nettype wire

// ===== src/access_judge.sv
// Combinational access permission decision
`timescale 1ns/10ps
`default_nettype none
module access_judge (
   guard_if.judge g
);
   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                     input logic [15:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction : in_range

   function automatic logic [2:0] block_of(input logic [15:0] a);
      return a[flash_guard_pkg::BLOCK_MSB:flash_guard_pkg::BLOCK_LSB];
   endfunction : block_of

   logic reserved;
   logic sec_page;
   logic lock_loc;
   logic sec_locked;
   logic below;
   logic pc_up;

   // ************************************************************
   // Decision
   // ************************************************************
   always_comb begin
      reserved     = g.addr >= flash_guard_pkg::RESERVED_BASE;
      sec_page     = in_range(g.addr, flash_guard_pkg::SEC_PAGE_BASE,
                              flash_guard_pkg::SEC_PAGE_LAST);
      lock_loc     = (g.addr == flash_guard_pkg::WRLOCK_ADDR) ||
                     (g.addr == flash_guard_pkg::RDLOCK_ADDR);
      sec_locked   = !g.wrlock[flash_guard_pkg::SEC_LOCK_BIT];
      below        = g.addr < g.limit;
      pc_up        = g.pc >= g.limit; // [RULE_23]
      g.allow      = 1'b0;
      g.full_erase = 1'b0;
      g.clear_sec  = 1'b0;
      g.zero_read  = 1'b0;
      if (g.src == flash_guard_pkg::SRC_DEBUG) begin
         if (reserved) begin
            g.allow = 1'b0; // [RULE_07]
         end else if (lock_loc && g.op == flash_guard_pkg::OP_READ) begin
            g.allow = 1'b1; // [RULE_03]
         end else if (lock_loc && g.op == flash_guard_pkg::OP_WRITE) begin
            g.allow = 1'b1; // [RULE_04]
         end else if (lock_loc && g.op == flash_guard_pkg::OP_ERASE && sec_locked) begin
            g.allow      = 1'b1; // [RULE_06]
            g.full_erase = 1'b1; // [RULE_06]
         end else if (sec_page && g.op == flash_guard_pkg::OP_ERASE) begin
            g.allow     = !sec_locked; // [RULE_05] [RULE_06]
            g.clear_sec = !sec_locked; // [RULE_05]
         end else if (g.op == flash_guard_pkg::OP_READ || g.op == flash_guard_pkg::OP_FETCH) begin
            g.allow = g.rdlock[block_of(g.addr)]; // [RULE_01] [RULE_02]
         end else begin
            g.allow = g.wrlock[block_of(g.addr)]; // [RULE_01] [RULE_02]
         end
      end else begin
         // Lock bytes deliberately not consulted on this path [RULE_08]
         if (g.scratch && g.op != flash_guard_pkg::OP_FETCH) begin
            g.allow = g.addr < flash_guard_pkg::SCRATCH_SIZE; // [RULE_20]
         end else if (reserved) begin
            g.allow = 1'b0; // [RULE_07]
         end else if (g.op == flash_guard_pkg::OP_FETCH) begin
            g.allow = 1'b1; // [RULE_14]
         end else if (sec_page && g.op == flash_guard_pkg::OP_ERASE) begin
            g.allow = 1'b0; // [RULE_10]
         end else if (sec_page) begin
            g.allow = 1'b1; // [RULE_11]
         end else if (pc_up && below) begin
            g.allow     = 1'b0; // [RULE_13]
            g.zero_read = g.op == flash_guard_pkg::OP_READ; // [RULE_22]
         end else begin
            g.allow = 1'b1; // [RULE_09] [RULE_12]
         end
         // Software program gates apply on top of the partition verdict
         if (g.op == flash_guard_pkg::OP_WRITE && !(g.prog_gate && g.write_en)) begin
            g.allow = 1'b0; // [RULE_18] [RULE_19]
         end
         if (g.op == flash_guard_pkg::OP_ERASE &&
             !(g.prog_gate && g.write_en && g.erase_en)) begin
            g.allow = 1'b0; // [RULE_18] [RULE_19]
         end
      end
   end
endmodule : access_judge
`default_nettype wire

// ===== tb/flash_guard_checker.sv
// Port-level assertions for the flash access guard
`timescale 1ns/10ps
`default_nettype none
module flash_guard_checker (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        req_valid,
   input wire logic        req_src,
   input wire logic [1:0]  req_op,
   input wire logic [15:0] req_addr,
   input wire logic [7:0]  wrlock_byte,
   input wire logic [7:0]  rdlock_byte,
   input wire logic        resp_valid,
   input wire logic        resp_allow,
   input wire logic        resp_full_erase,
   input wire logic        resp_clear_security,
   input wire logic        resp_zero_read
);
   // ********************************
   // Verdict relations
   // ********************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   logic dbg, fw, sec, lk, rd, wr, er;
   assign dbg = req_valid && !req_src;
   assign fw  = req_valid && req_src;
   assign sec = req_addr[15:9] == 7'h7d;
   assign lk  = req_addr[15:1] == 15'h7dff;
   assign rd  = req_op == flash_guard_pkg::OP_READ;
   assign wr  = req_op == flash_guard_pkg::OP_WRITE;
   assign er  = req_op == flash_guard_pkg::OP_ERASE;
   chk_resp_timing: assert property (resp_valid == $past(req_valid))
      else $error("verdict not one cycle after request");
   chk_reserved_denied: assert property (req_valid && req_addr >= 16'hfc00 |=> !resp_allow)
      else $error("reserved area granted");
   chk_fw_sec_erase: assert property (fw && er && sec |=> resp_valid && !resp_allow)
      else $error("firmware erased security page");
   chk_dbg_lock_read: assert property (dbg && rd && lk |=> resp_allow)
      else $error("debug lock byte read refused");
   chk_dbg_lock_write: assert property (dbg && wr && lk |=> resp_allow)
      else $error("debug lock byte write refused");
   chk_fw_fetch_ok: assert property (fw && req_op == flash_guard_pkg::OP_FETCH
      && req_addr < 16'hfc00 |=> resp_allow && !resp_zero_read)
      else $error("firmware branch refused");
   chk_locked_full: assert property (dbg && er && lk && !wrlock_byte[7]
      |=> resp_full_erase && !resp_clear_security)
      else $error("locked security erase not full");
   chk_unlocked_clear: assert property (dbg && er && lk && wrlock_byte[7]
      |=> resp_clear_security && !resp_full_erase)
      else $error("unlocked security erase not clearing");
   chk_dbg_read_locked: assert property (dbg && rd && req_addr < 16'hfa00
      && !rdlock_byte[req_addr[15:13]] |=> resp_valid && !resp_allow)
      else $error("locked block read granted");
   chk_zero_denied: assert property (resp_zero_read |-> resp_valid && !resp_allow)
      else $error("zero read on granted access");
endmodule : flash_guard_checker

bind flash_access_guard flash_guard_checker u_chk (
   .clk(clk), .nrst(nrst), .req_valid(req_valid), .req_src(req_src), .req_op(req_op),
   .req_addr(req_addr), .wrlock_byte(wrlock_byte), .rdlock_byte(rdlock_byte),
   .resp_valid(resp_valid), .resp_allow(resp_allow), .resp_full_erase(resp_full_erase),
   .resp_clear_security(resp_clear_security), .resp_zero_read(resp_zero_read)
);
`default_nettype wire

// ===== tb/lock_store_model.sv
// Behavioural store of the two security lock bytes
`timescale 1ns/10ps
`default_nettype none
module lock_store_model (
   input  wire logic       clk,
   input  wire logic       load,
   input  wire logic [7:0] wl_in,
   input  wire logic [7:0] rl_in,
   input  wire logic       erased,
   output logic      [7:0] wl,
   output logic      [7:0] rl
);
   // Non-volatile, so no reset; erased flash reads all ones
   always_ff @(posedge clk) begin
      if (erased) begin
         wl <= 8'hff;
         rl <= 8'hff;
      end else if (load) begin
         wl <= wl_in;
         rl <= rl_in;
      end
   end
endmodule : lock_store_model
`default_nettype wire

// ===== tb/flash_access_guard_tb.sv
// Self-checking bench for the flash access guard
`timescale 1ns/10ps
`default_nettype none
module flash_access_guard_tb;
   localparam logic [1:0] RD = flash_guard_pkg::OP_READ;
   localparam logic [1:0] WR = flash_guard_pkg::OP_WRITE;
   localparam logic [1:0] ER = flash_guard_pkg::OP_ERASE;
   localparam logic [1:0] FE = flash_guard_pkg::OP_FETCH;
   localparam logic [7:0] FT = flash_guard_pkg::FTC_ADDR;
   localparam logic [7:0] PS = flash_guard_pkg::PSC_ADDR;
   localparam logic [7:0] AL = flash_guard_pkg::ALR_ADDR;
   logic        clk, nrst, sfr_wr, sfr_rd, req_valid, req_src, ld, rd_q, lim_set;
   logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, lw, lr, wl, rl, lim;
   logic [1:0]  req_op;
   logic [15:0] req_addr, req_pc;
   logic        v, al, fe, cs, zr, sc, sa, gate, we, ee, scr;
   logic [4:0]  vq[$];
   logic [7:0]  rq[$];
   int          errors, n_checks, cyc;

   flash_access_guard u_dut (.clk(clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .req_valid(req_valid),
      .req_src(req_src), .req_op(req_op), .req_addr(req_addr), .req_pc(req_pc),
      .wrlock_byte(wl), .rdlock_byte(rl), .resp_valid(v), .resp_allow(al),
      .resp_full_erase(fe), .resp_clear_security(cs), .resp_zero_read(zr),
      .resp_scratch(sc), .sense_amp_on(sa));
   lock_store_model u_locks (.clk(clk), .load(ld), .wl_in(lw), .rl_in(lr),
      .erased(al & (fe | cs)), .wl(wl), .rl(rl));

   // ********************************
   // Reference verdict
   // ********************************
   function automatic logic [4:0] ref_v(logic s, logic [1:0] o, logic [15:0] a, logic [15:0] p);
      logic ok, f, c, z, k, lkb, pm;
      ok = 0; f = 0; c = 0; z = 0; k = 0;
      lkb = a[15:1] == 15'h7dff;
      pm = o == RD || (gate && we && (o == WR || ee));
      if (!s) begin
         if (a >= 16'hfc00) ok = 0;
         else if (o == ER && lkb) begin
            ok = 1; f = !wl[7]; c = wl[7];
         end else if (o == RD || o == FE) ok = lkb | rl[a[15:13]];
         else ok = lkb | wl[a[15:13]];
      end else if (o == FE) ok = a < 16'hfc00;
      else if (scr) begin
         ok = a < 16'h0080 && pm; k = 1;
      end else if (a >= 16'hfc00 || (o == ER && a[15:9] == 7'h7d)) ok = 0;
      else if (p >= {lim, 8'h00} && a < {lim, 8'h00}) z = o == RD;
      else ok = pm;
      return {ok, f, c, z, k};
   endfunction : ref_v

   task automatic cmp(string what, logic [7:0] e, logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, e, g);
      end
   endtask : cmp

   task automatic cmp_verdict(logic [4:0] e);
      cmp("verdict", {3'b000, e}, {3'b000, al, fe, cs, zr, sc});
   endtask : cmp_verdict

   task automatic cmp_reg(logic [7:0] e);
      cmp("register", e, sfr_rdata);
   endtask : cmp_reg

   task automatic cmp_sense(logic e);
      cmp("sense", {7'h00, e}, {7'h00, sa});
   endtask : cmp_sense

   task automatic complete_run;
      $display("checks %0d, errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : complete_run

   task automatic wr(logic [7:0] a, logic [7:0] d);
      if (a == FT) gate = d[0];
      if (a == PS) {scr, ee, we} = d[2:0];
      if (a == AL && !lim_set) begin
         lim = d; lim_set = 1;
      end
      sfr_addr = a; sfr_wdata = d; sfr_wr = 1;
      @(negedge clk);
      sfr_wr = 0;
      @(negedge clk);
   endtask : wr

   task automatic rd(logic [7:0] a, logic [7:0] e);
      rq.push_back(e);
      sfr_addr = a; sfr_rd = 1;
      @(negedge clk);
      sfr_rd = 0;
      @(negedge clk);
   endtask : rd

   // Valid stays high between calls so back-to-back requests reach the port
   task automatic req(logic s, logic [1:0] o, logic [15:0] a, logic [15:0] p);
      vq.push_back(ref_v(s, o, a, p));
      req_valid = 1; req_src = s; req_op = o; req_addr = a; req_pc = p;
      @(negedge clk);
   endtask : req

   task automatic quiet(int n);
      req_valid = 0;
      repeat (n) @(negedge clk);
   endtask : quiet

   task automatic load(logic [7:0] w, logic [7:0] r);
      lw = w; lr = r; ld = 1;
      @(negedge clk);
      ld = 0;
   endtask : load

   // ********************************
   // Monitors, clock and timeout
   // ********************************
   always @(posedge clk) rd_q <= sfr_rd;
   always @(negedge clk) begin
      if (v === 1'b1) cmp_verdict(vq.pop_front());
      if (rd_q === 1'b1) cmp_reg(rq.pop_front());
   end
   initial begin
      clk = 0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         complete_run();
      end
   end

   initial begin
      {nrst, sfr_wr, sfr_rd, req_valid, req_src, lim_set, gate, we, ee, scr} = '0;
      {sfr_addr, sfr_wdata, lim, req_op, req_addr, req_pc, errors, n_checks} = '0;
      lw = 8'hff; lr = 8'hff; ld = 1;
      void'($urandom(32'h7e0c67e0));
      repeat (6) @(negedge clk);
      nrst = 1; ld = 0;
      rd(FT, 8'h80);
      rd(PS, 8'h00);
      rd(AL, 8'h00);
      rd(8'h10, 8'h00);
      wr(FT, 8'hc1);
      rd(FT, 8'hc1);
      cmp_sense(1'b1);
      wr(FT, 8'h80);
      wr(PS, 8'h03);
      rd(PS, 8'h03);
      req(1, WR, 16'h2000, 16'h0100);
      quiet(1); wr(FT, 8'h81);
      req(1, WR, 16'h2000, 16'h0100);
      req(1, ER, 16'h2000, 16'h0100);
      quiet(1); wr(PS, 8'h00);
      req(1, WR, 16'h2000, 16'h0100);
      quiet(1); wr(PS, 8'h03); wr(AL, 8'h40); wr(AL, 8'h20);
      rd(AL, 8'h40);
      req(1, RD, 16'h0100, 16'h8000);
      req(1, WR, 16'h4000, 16'h8000);
      req(1, ER, 16'h3e00, 16'h8000);
      req(1, FE, 16'h0100, 16'h8000);
      req(1, WR, 16'hfbfe, 16'h8000);
      req(1, ER, 16'hfa00, 16'h8000);
      req(1, WR, 16'hfc10, 16'h8000);
      req(1, RD, 16'h9000, 16'h0200);
      req(0, RD, 16'h1234, 16'h0000);
      quiet(1); load(8'h7f, 8'hfe);
      req(0, RD, 16'h0100, 16'h0000);
      req(0, RD, 16'hfbff, 16'h0000);
      req(0, WR, 16'hfbfe, 16'h0000);
      req(0, RD, 16'hfc40, 16'h0000);
      req(1, RD, 16'h0100, 16'h0200);
      req(0, ER, 16'hfbfe, 16'h0000);
      quiet(2);
      req(0, ER, 16'hfbff, 16'h0000);
      quiet(2); load(8'($urandom), 8'($urandom));
      repeat (60) req(1'($urandom), 2'($urandom), 16'($urandom) & 16'hf9ff, 16'($urandom));
      quiet(1); wr(PS, 8'h07);
      req(1, RD, 16'h0010, 16'h8000);
      quiet(flash_guard_pkg::SENSE_HOLD_CYCLES - 1);
      cmp_sense(1'b1);
      @(negedge clk);
      cmp_sense(1'b0);
      cmp("pending", 8'h00, 8'(vq.size()));
      complete_run();
   end
endmodule : flash_access_guard_tb
`default_nettype wire
